// ### shared/bank_c_defs.svh
`ifndef BANK_C_DEFS_SVH
`define BANK_C_DEFS_SVH
// Contract
// [RULE1] Divide code bits 5:0 at 0x20, reset 0x0d; some codes reserved.
// [RULE2] A new divide code takes effect only when the apply bit toggles.
// [RULE3] Bank power-down, bit 7 at 0x22, reset 0, stops bank and outputs.
// [RULE4] Software also sets both output power-down bits when bank goes down.
// [RULE5] Source select 0 (reset): divide code and bank power-down from pins.
// [RULE6] Source select 1: divide code and bank power-down from registers.
// [RULE7] Output power-down bit 7 at 0x24 and 0x25, reset 0, one per output.
// [RULE8] Reserved bits are written as zero; their read value is undefined.
// [RULE9] Pins pick divide code and power-down from a configurable table.

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define BANK_C_OFS_DIVIDE 8'h20
`define BANK_C_OFS_RSVD_A 8'h21
`define BANK_C_OFS_POWER_SOURCE 8'h22
`define BANK_C_OFS_RSVD_B 8'h23
`define BANK_C_OFS_OUT0_PD 8'h24
`define BANK_C_OFS_OUT1_PD 8'h25

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define BANK_C_DIV_MSB 5
`define BANK_C_PD_BIT 7
`define BANK_C_SRC_BIT 0
`define BANK_C_DIV_RESET 6'h0d
`define BANK_C_BIT_RESET 1'h0
`define BANK_C_BYTE_ZERO 8'h00
`define BANK_C_NUM_OUTPUTS 2

// ---------------------------------------------------------------
// Default pin table (arbitrary plain values)
// ---------------------------------------------------------------
`define BANK_C_PIN_CODES '{6'h0d, 6'h0f, 6'h09, 6'h07}
`define BANK_C_PIN_PDS '{1'h0, 1'h0, 1'h0, 1'h1}

`endif

// ### shared/bank_c_pkg.sv
package bank_c_pkg;

	typedef logic [5:0] div_code_t;
	typedef logic [7:0] div_ratio_t;
	typedef logic [7:0] reg_byte_t;

	// Ratio per code; reserved codes show 0
	localparam div_ratio_t ratio_table [64] = '{
		8'h00, 8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08,
		8'h09, 8'h0a, 8'h0c, 8'h0e, 8'h0f, 8'h10, 8'h12, 8'h14,
		8'h15, 8'h16, 8'h18, 8'h19, 8'h1b, 8'h1c, 8'h1e, 8'h20,
		8'h21, 8'h23, 8'h24, 8'h28, 8'h2a, 8'h2c, 8'h2d, 8'h30,
		8'h32, 8'h36, 8'h37, 8'h38, 8'h3c, 8'h40, 8'h42, 8'h46,
		8'h48, 8'h50, 8'h54, 8'h58, 8'h5a, 8'h60, 8'h64, 8'h6c,
		8'h6e, 8'h70, 8'h78, 8'h80, 8'h84, 8'h8c, 8'h90,
		8'ha0, 8'hb0, 8'hb4, 8'hc8, 8'hdc,
		8'h00, 8'h00, 8'h00, 8'h00
	};

endpackage : bank_c_pkg

// ### core/bank_c_divider_control.sv
`timescale 1ns/100ps
`include "bank_c_defs.svh"

module bank_c_divider_control #(
	parameter logic [5:0] PIN_CODE_TABLE [4] = `BANK_C_PIN_CODES,
	parameter logic PIN_PD_TABLE [4] = `BANK_C_PIN_PDS
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_apply_toggle,
	input wire logic [1:0] i_ctrl_pins,
	output logic [7:0] o_rdata,
	output logic [5:0] o_divide_code,
	output logic [7:0] o_divide_ratio,
	output logic o_bank_powerdown,
	output logic [1:0] o_output_powerdown
);

	// -----------------------------------------------------------
	// State
	// -----------------------------------------------------------
	bank_c_pkg::div_code_t divide_code;
	bank_c_pkg::div_code_t next_divide_code;
	logic bank_c_powerdown;
	logic next_bank_c_powerdown;
	logic bank_c_source_select;
	logic next_bank_c_source_select;
	logic [1:0] output_c_powerdown;
	logic [1:0] next_output_c_powerdown;
	bank_c_pkg::reg_byte_t rdata;
	bank_c_pkg::reg_byte_t next_rdata;
	logic [1:0] pin_s1;
	logic [1:0] pin_s2;
	logic [1:0] pin_s3;
	logic [1:0] pin_stable;
	logic [1:0] next_pin_stable;
	logic apply_prev;
	logic next_apply_prev;
	bank_c_pkg::div_code_t applied_code;
	bank_c_pkg::div_code_t next_applied_code;
	bank_c_pkg::div_ratio_t applied_ratio;
	bank_c_pkg::div_ratio_t next_applied_ratio;
	logic bank_pd_out;
	logic next_bank_pd_out;
	logic [1:0] out_pd;
	logic [1:0] next_out_pd;

	logic apply_evt;
	bank_c_pkg::div_code_t eff_code;
	logic eff_pd;

	function automatic bank_c_pkg::reg_byte_t pd_byte(input logic bit_v);
		bank_c_pkg::reg_byte_t b;
		b = `BANK_C_BYTE_ZERO;
		b[`BANK_C_PD_BIT] = bit_v;
		return b;
	endfunction : pd_byte

	// -----------------------------------------------------------
	// Pin synchroniser
	// -----------------------------------------------------------
	// Three stages; the first is read only by the second
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			pin_s1 <= {2{`BANK_C_BIT_RESET}};
			pin_s2 <= {2{`BANK_C_BIT_RESET}};
			pin_s3 <= {2{`BANK_C_BIT_RESET}};
		end else if (i_ce) begin
			pin_s1 <= i_ctrl_pins;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	always_comb begin
		next_pin_stable = pin_stable;
		if (i_ce && (pin_s2 == pin_s3)) begin
			next_pin_stable = pin_s3;
		end
	end

	// -----------------------------------------------------------
	// Source selection
	// -----------------------------------------------------------
	always_comb begin
		// [RULE6] Register-sourced settings
		eff_code = divide_code;
		eff_pd = bank_c_powerdown;
		if (!bank_c_source_select) begin
			// [RULE5] Pin-sourced settings
			// [RULE9] Table lookup of pins
			eff_code = PIN_CODE_TABLE[pin_stable];
			eff_pd = PIN_PD_TABLE[pin_stable];
		end
	end

	assign apply_evt = i_apply_toggle != apply_prev;

	// -----------------------------------------------------------
	// Register file
	// -----------------------------------------------------------
	always_comb begin
		next_divide_code = divide_code;
		next_bank_c_powerdown = bank_c_powerdown;
		next_bank_c_source_select = bank_c_source_select;
		next_output_c_powerdown = output_c_powerdown;
		next_rdata = rdata;
		if (i_ce && i_wr) begin
			case (i_addr)
				`BANK_C_OFS_DIVIDE: begin
					// [RULE1] Store divide code
					next_divide_code = i_wdata[`BANK_C_DIV_MSB:0];
				end
				`BANK_C_OFS_POWER_SOURCE: begin
					next_bank_c_powerdown = i_wdata[`BANK_C_PD_BIT];
					next_bank_c_source_select = i_wdata[`BANK_C_SRC_BIT];
				end
				`BANK_C_OFS_OUT0_PD: begin
					// [RULE7] Per-output bit
					next_output_c_powerdown[0] = i_wdata[`BANK_C_PD_BIT];
				end
				`BANK_C_OFS_OUT1_PD: begin
					next_output_c_powerdown[1] = i_wdata[`BANK_C_PD_BIT];
				end
				default: begin
				end
			endcase
		end
		if (i_ce && i_rd) begin
			// [RULE8] Reserved bits read zero
			case (i_addr)
				`BANK_C_OFS_DIVIDE: begin
					next_rdata = {2'h0, divide_code};
				end
				`BANK_C_OFS_POWER_SOURCE: begin
					next_rdata = pd_byte(bank_c_powerdown);
					next_rdata[`BANK_C_SRC_BIT] = bank_c_source_select;
				end
				`BANK_C_OFS_OUT0_PD: begin
					next_rdata = pd_byte(output_c_powerdown[0]);
				end
				`BANK_C_OFS_OUT1_PD: begin
					next_rdata = pd_byte(output_c_powerdown[1]);
				end
				default: begin
					next_rdata = `BANK_C_BYTE_ZERO;
				end
			endcase
		end
	end

	// -----------------------------------------------------------
	// Applied settings
	// -----------------------------------------------------------
	always_comb begin
		next_apply_prev = apply_prev;
		next_applied_code = applied_code;
		next_applied_ratio = applied_ratio;
		next_bank_pd_out = bank_pd_out;
		next_out_pd = out_pd;
		if (i_ce) begin
			next_apply_prev = i_apply_toggle;
			// [RULE2] Divider latches only on toggle
			if (apply_evt) begin
				next_applied_code = eff_code;
				next_applied_ratio = bank_c_pkg::ratio_table[eff_code];
			end
			// [RULE3] Bank down forces outputs down
			next_bank_pd_out = eff_pd;
			next_out_pd = output_c_powerdown | {2{eff_pd}};
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			divide_code <= `BANK_C_DIV_RESET;
			bank_c_powerdown <= `BANK_C_BIT_RESET;
			bank_c_source_select <= `BANK_C_BIT_RESET;
			output_c_powerdown <= {2{`BANK_C_BIT_RESET}};
			rdata <= `BANK_C_BYTE_ZERO;
			pin_stable <= {2{`BANK_C_BIT_RESET}};
			apply_prev <= `BANK_C_BIT_RESET;
			applied_code <= `BANK_C_DIV_RESET;
			applied_ratio <= bank_c_pkg::ratio_table[`BANK_C_DIV_RESET];
			bank_pd_out <= `BANK_C_BIT_RESET;
			out_pd <= {2{`BANK_C_BIT_RESET}};
		end else begin
			divide_code <= next_divide_code;
			bank_c_powerdown <= next_bank_c_powerdown;
			bank_c_source_select <= next_bank_c_source_select;
			output_c_powerdown <= next_output_c_powerdown;
			rdata <= next_rdata;
			pin_stable <= next_pin_stable;
			apply_prev <= next_apply_prev;
			applied_code <= next_applied_code;
			applied_ratio <= next_applied_ratio;
			bank_pd_out <= next_bank_pd_out;
			out_pd <= next_out_pd;
		end
	end

	assign o_rdata = rdata;
	assign o_divide_code = applied_code;
	assign o_divide_ratio = applied_ratio;
	assign o_bank_powerdown = bank_pd_out;
	assign o_output_powerdown = out_pd;

	// -----------------------------------------------------------
	// Checks
	// -----------------------------------------------------------
	AST_DIV_RESET: assert property (@(posedge i_ref_clk) // [RULE1]
		$fell(i_rst) |-> divide_code == `BANK_C_DIV_RESET
			&& o_divide_code == `BANK_C_DIV_RESET)
		else $error("divide code not at reset value");

	AST_APPLY_HOLD: assert property (@(posedge i_ref_clk) // [RULE2]
		disable iff (i_rst) (!apply_evt || !i_ce) |=> $stable(o_divide_code))
		else $error("divider changed without apply toggle");

	AST_APPLY_TAKE: assert property (@(posedge i_ref_clk) // [RULE2]
		disable iff (i_rst) (apply_evt && i_ce)
			|=> o_divide_code == $past(eff_code)
			&& o_divide_ratio == bank_c_pkg::ratio_table[o_divide_code])
		else $error("apply toggle did not load divider");

	AST_BANK_PD: assert property (@(posedge i_ref_clk) // [RULE3]
		disable iff (i_rst) o_bank_powerdown |-> o_output_powerdown == 2'h3)
		else $error("outputs running while bank down");

	AST_PIN_MODE: assert property (@(posedge i_ref_clk) // [RULE5]
		disable iff (i_rst) (!bank_c_source_select && i_ce)
			|=> o_bank_powerdown == PIN_PD_TABLE[$past(pin_stable)])
		else $error("pin mode power-down mismatch");

	AST_REG_MODE: assert property (@(posedge i_ref_clk) // [RULE6]
		disable iff (i_rst) (bank_c_source_select && i_ce)
			|=> o_bank_powerdown == $past(bank_c_powerdown))
		else $error("register mode power-down mismatch");

	AST_OUT_PD: assert property (@(posedge i_ref_clk) // [RULE7]
		disable iff (i_rst) (i_ce && i_wr && i_addr == `BANK_C_OFS_OUT1_PD)
			##1 i_ce |=> o_output_powerdown[1]
			== ($past(i_wdata[`BANK_C_PD_BIT], 2) | o_bank_powerdown))
		else $error("output power-down write not honoured");

	AST_RSVD_READ: assert property (@(posedge i_ref_clk) // [RULE8]
		disable iff (i_rst) (i_ce && i_rd && i_addr == `BANK_C_OFS_RSVD_A)
			|=> o_rdata == `BANK_C_BYTE_ZERO)
		else $error("reserved register read not zero");

	AST_PIN_TABLE: assert property (@(posedge i_ref_clk) // [RULE9]
		disable iff (i_rst) (!bank_c_source_select && apply_evt && i_ce)
			|=> o_divide_code == PIN_CODE_TABLE[$past(pin_stable)])
		else $error("pin table code not applied");

	COV_REG_APPLY: cover property (@(posedge i_ref_clk) disable iff (i_rst)
		bank_c_source_select && apply_evt && i_ce);
	COV_PIN_APPLY: cover property (@(posedge i_ref_clk) disable iff (i_rst)
		!bank_c_source_select && apply_evt && i_ce);
	COV_BANK_DOWN: cover property (@(posedge i_ref_clk) disable iff (i_rst)
		$rose(o_bank_powerdown));

endmodule : bank_c_divider_control

// ### test/bank_c_host_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Processor and control pin model
// ---------------------------------------------------------------
module bank_c_host_model (
	input wire logic i_ref_clk,
	input wire logic [7:0] i_rdata,
	output logic o_ce,
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_apply_toggle,
	output logic [1:0] o_ctrl_pins
);
	initial begin
		o_ce = 1'h1;
		o_wr = 1'h0;
		o_rd = 1'h0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_apply_toggle = 1'h0;
		o_ctrl_pins = 2'h0;
	end
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		o_wr <= 1'h1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_ref_clk);
		o_wr <= 1'h0;
		// Idle data moves so a stale copy is never trusted
		o_wdata <= ~d;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_ref_clk);
		o_rd <= 1'h1;
		o_addr <= a;
		@(posedge i_ref_clk);
		o_rd <= 1'h0;
		#1;
		d = i_rdata;
	endtask : rd_reg
	task automatic toggle();
		@(posedge i_ref_clk);
		o_apply_toggle <= ~o_apply_toggle;
	endtask : toggle
	task automatic set_ce(input logic v);
		@(posedge i_ref_clk);
		o_ce <= v;
	endtask : set_ce
	task automatic set_pins(input logic [1:0] v);
		@(posedge i_ref_clk);
		o_ctrl_pins <= v;
	endtask : set_pins
	task automatic bank_down();
		wr_reg(8'h24, 8'h80);
		wr_reg(8'h25, 8'h80);
		wr_reg(8'h22, 8'h81);
	endtask : bank_down
endmodule : bank_c_host_model

// ### test/bank_c_divider_control_test.sv
`timescale 1ns/100ps
module bank_c_divider_control_test;
	logic ref_clk, rst, ce, wr, rd, tog, bank_pd;
	logic [7:0] addr, wdata, rdata, ratio, val;
	logic [5:0] code;
	logic [1:0] out_pd, pins;
	int num_errors = 0;
	int check_count = 0;

	initial begin
		ref_clk = 1'h0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	bank_c_divider_control i_bank_c_divider_control (
		.i_ref_clk(ref_clk), .i_rst(rst), .i_ce(ce), .i_wr(wr), .i_rd(rd),
		.i_addr(addr), .i_wdata(wdata), .i_apply_toggle(tog),
		.i_ctrl_pins(pins), .o_rdata(rdata), .o_divide_code(code),
		.o_divide_ratio(ratio), .o_bank_powerdown(bank_pd),
		.o_output_powerdown(out_pd));
	bank_c_host_model i_bank_c_host_model (
		.i_ref_clk(ref_clk), .i_rdata(rdata), .o_ce(ce), .o_wr(wr),
		.o_rd(rd), .o_addr(addr), .o_wdata(wdata),
		.o_apply_toggle(tog), .o_ctrl_pins(pins));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic check(string s, logic [7:0] e, logic [7:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask : check
	task automatic wr_(logic [7:0] a, logic [7:0] d);
		i_bank_c_host_model.wr_reg(a, d);
	endtask : wr_
	task automatic rd_check(logic [7:0] a, logic [7:0] e);
		i_bank_c_host_model.rd_reg(a, val);
		check("rdata", e, val);
	endtask : rd_check
	task automatic settle();
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : settle
	task automatic apply();
		i_bank_c_host_model.toggle();
		settle();
	endtask : apply
	// Pin path has a synchroniser, so poll under a bound
	task automatic wait_pd(logic e);
		int n;
		n = 0;
		#1;
		while (bank_pd !== e && n < 12) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check("bank_pd", {7'h00, e}, {7'h00, bank_pd});
	endtask : wait_pd

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic test_reset();
		check("code", 8'h0d, {2'h0, code});
		check("ratio", 8'h10, ratio);
		rd_check(8'h20, 8'h0d);
		rd_check(8'h22, 8'h00);
		rd_check(8'h24, 8'h00);
		rd_check(8'h25, 8'h00);
		$display("test_reset done");
	endtask : test_reset
	task automatic test_pins();
		i_bank_c_host_model.set_pins(2'h3);
		wait_pd(1'h1);
		check("out_pd", 8'h03, {6'h00, out_pd});
		apply();
		check("code", 8'h07, {2'h0, code});
		check("ratio", 8'h08, ratio);
		wr_(8'h20, 8'h02);
		apply();
		check("code", 8'h07, {2'h0, code});
		i_bank_c_host_model.set_pins(2'h1);
		wait_pd(1'h0);
		apply();
		check("code", 8'h0f, {2'h0, code});
		$display("test_pins done");
	endtask : test_pins
	task automatic test_regs();
		wr_(8'h22, 8'h01);
		wr_(8'h20, 8'h3b);
		settle();
		check("code", 8'h0f, {2'h0, code});
		apply();
		check("code", 8'h3b, {2'h0, code});
		check("ratio", 8'hdc, ratio);
		wr_(8'h20, 8'h02);
		apply();
		check("ratio", 8'h02, ratio);
		i_bank_c_host_model.set_pins(2'h3);
		repeat (3) settle();
		check("bank_pd", 8'h00, {7'h00, bank_pd});
		$display("test_regs done");
	endtask : test_regs
	task automatic test_powerdown();
		wr_(8'h22, 8'h81);
		settle();
		check("bank_pd", 8'h01, {7'h00, bank_pd});
		check("out_pd", 8'h03, {6'h00, out_pd});
		wr_(8'h22, 8'h01);
		wr_(8'h24, 8'h80);
		settle();
		check("out_pd", 8'h01, {6'h00, out_pd});
		rd_check(8'h24, 8'h80);
		wr_(8'h24, 8'h00);
		wr_(8'h25, 8'h80);
		settle();
		check("out_pd", 8'h02, {6'h00, out_pd});
		i_bank_c_host_model.bank_down();
		settle();
		check("out_pd", 8'h03, {6'h00, out_pd});
		rd_check(8'h22, 8'h81);
		$display("test_powerdown done");
	endtask : test_powerdown
	task automatic test_reserved();
		wr_(8'h21, 8'h00);
		rd_check(8'h21, 8'h00);
		rd_check(8'h40, 8'h00);
		wr_(8'h20, 8'h3f);
		apply();
		check("ratio", 8'h00, ratio);
		rd_check(8'h20, 8'h3f);
		$display("test_reserved done");
	endtask : test_reserved
	// Enable low: writes are dropped, toggles wait, state frozen
	task automatic test_hold();
		i_bank_c_host_model.set_ce(1'h0);
		wr_(8'h22, 8'h01);
		wr_(8'h20, 8'h05);
		i_bank_c_host_model.toggle();
		settle();
		check("bank_pd", 8'h01, {7'h00, bank_pd});
		check("code", 8'h3f, {2'h0, code});
		i_bank_c_host_model.set_ce(1'h1);
		settle();
		check("code", 8'h3f, {2'h0, code});
		rd_check(8'h20, 8'h3f);
		rd_check(8'h22, 8'h81);
		$display("test_hold done");
	endtask : test_hold

	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test

	initial begin
		rst = 1'h1;
		repeat (10) @(posedge ref_clk);
		rst <= 1'h0;
		settle();
		test_reset();
		test_pins();
		test_regs();
		test_powerdown();
		test_reserved();
		test_hold();
		finish_test();
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		$display("BAD run expected done seen hang");
		finish_test();
	end
endmodule : bank_c_divider_control_test
